// *** verilog/synth_regs_pkg.sv ***
// constants shared by the synthesizer register bank and its serial receiver
package synth_regs_pkg;
    // ==========================================================
    // serial word format
    localparam int          WORD_W       = 24;
    localparam int          SYNC_W       = 3;
    localparam logic [1:0]  SEL_N_DIV    = 2'b00;
    localparam logic [1:0]  SEL_R_DIV    = 2'b01;
    localparam logic [1:0]  SEL_CTRL     = 2'b10;
    localparam logic [1:0]  SEL_NOISE    = 2'b11;
    // ==========================================================
    // register widths and reset values
    localparam int          N_REG_W      = 24;
    localparam int          R_REG_W      = 24;
    localparam int          CTRL_REG_W   = 16;
    localparam int          NOISE_REG_W  = 11;
    localparam logic [23:0] N_REG_RST    = 24'h00_0000;
    localparam logic [23:0] R_REG_RST    = 24'h00_0000;
    localparam logic [15:0] CTRL_REG_RST = 16'h0000;
    localparam logic [10:0] NOISE_REG_RST = 11'h000;
    // ==========================================================
    // n divider register fields
    localparam int          N_FASTLOCK_BIT = 23;
    localparam int          N_INT_LSB      = 14;
    localparam int          INT_W          = 9;
    localparam int          N_FRAC_LSB     = 2;
    localparam int          FRAC_W         = 12;
    // ==========================================================
    // r divider register fields
    localparam int          R_LOAD_BIT   = 23;
    localparam int          R_MUX_LSB    = 20;
    localparam int          MUX_W        = 3;
    localparam int          R_PRESC_BIT  = 18;
    localparam int          R_RDIV_LSB   = 14;
    localparam int          RDIV_W       = 4;
    localparam int          R_MOD_LSB    = 2;
    localparam int          MOD_W        = 12;
    // ==========================================================
    // control register fields
    localparam int          C_CRST_BIT   = 2;
    localparam int          C_CP3_BIT    = 3;
    localparam int          C_PD_BIT     = 4;
    localparam int          C_LDP_BIT    = 5;
    localparam int          C_POL_BIT    = 6;
    localparam int          C_CPI_LSB    = 7;
    localparam int          CPI_W        = 4;
    localparam int          C_DBL_BIT    = 11;
    localparam int          C_RSYNC_LSB  = 12;
    localparam int          RSYNC_W      = 4;
    // ==========================================================
    // noise and spur register fields and modes {upper four, low bit}
    localparam int          NS_LO_BIT    = 2;
    localparam int          NS_HI_LSB    = 6;
    localparam int          NS_MODE_W    = 5;
    localparam logic [4:0]  MODE_LOW_SPUR       = 5'h00;
    localparam logic [4:0]  MODE_LOW_NOISE_SPUR = 5'h1C;
    localparam logic [4:0]  MODE_LOWEST_NOISE   = 5'h1F;
    // ==========================================================
    // lock detect consecutive comparison cycle counts
    localparam int          LOCK_CNT_W    = 6;
    localparam logic [5:0]  LOCK_CYC_FINE = 6'h18;  // 24 cycles
    localparam logic [5:0]  LOCK_CYC_SLOW = 6'h28;  // 40 cycles
endpackage : synth_regs_pkg

// *** verilog/serial_word_receiver.sv ***
// three-wire serial receiver: shifts data on clock rises, hands a word on latch rise
`timescale 1ns/1ps
module serial_word_receiver
    import synth_regs_pkg::*;
(
    // clock, reset, enable
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              ce_in,
    // serial pins
    input  wire logic              ser_clk_in,
    input  wire logic              ser_data_in,
    input  wire logic              ser_latch_in,
    // received word
    output logic [WORD_W-1:0]      word_out,
    output logic                   word_valid_out
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] lvl;
        logic [WORD_W-1:0] shift;
        logic [WORD_W-1:0] word;
        logic              valid;
    } rx_state_t;

    rx_state_t st_r;
    rx_state_t st_nxt;
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] rise;

    assign pins = {ser_latch_in, ser_data_in, ser_clk_in};

    // ==========================================================
    // next state: a pin level counts once stages two and three agree
    always_comb begin
        st_nxt       = st_r;
        st_nxt.s1    = pins;
        st_nxt.s2    = st_r.s1;
        st_nxt.s3    = st_r.s2;
        st_nxt.valid = 1'b0;
        rise         = '0;
        for (int i = 0; i < SYNC_W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
                rise[i]       = st_r.s3[i] & ~st_r.lvl[i];
            end
        end
        // data is sampled on the agreed level, one cycle older than the clock edge seen in stage three
        if (rise[0]) begin
            st_nxt.shift = {st_r.shift[WORD_W-2:0], st_r.lvl[1]};
        end
        // words still latch while powered down
        if (rise[2]) begin
            st_nxt.word  = st_r.shift;
            st_nxt.valid = 1'b1;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign word_out       = st_r.word;
    assign word_valid_out = st_r.valid & ce_in;
endmodule : serial_word_receiver

// *** verilog/synth_control_registers.sv ***
// write-only configuration registers and reference/lock logic of the synthesizer
`timescale 1ns/1ps
module synth_control_registers
    import synth_regs_pkg::*;
#(
    parameter int LOCK_W = LOCK_CNT_W
)
(
    // clock, reset, enable
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 ce_in,
    // three-wire serial interface
    input  wire logic                 ser_clk_in,
    input  wire logic                 ser_data_in,
    input  wire logic                 ser_latch_in,
    // reference and phase error comparators
    input  wire logic                 reference_input_in,
    input  wire logic                 err_below_15ns_in,
    input  wire logic                 err_above_30ns_in,
    // divider settings
    output logic [INT_W-1:0]          whole_divide_value_out,
    output logic [FRAC_W-1:0]         partial_step_count_out,
    output logic [MOD_W-1:0]          channel_step_divisor_out,
    output logic [MOD_W-1:0]          resync_delay_out,
    output logic [RDIV_W-1:0]         ref_divider_out,
    output logic                      fastlock_out,
    output logic                      prescaler_sel_out,
    output logic [MUX_W-1:0]          multiplexed_output_sel_out,
    // control settings
    output logic                      counters_reset_out,
    output logic                      cp_three_state_out,
    output logic                      power_down_out,
    output logic                      pd_polarity_out,
    output logic [CPI_W-1:0]          cp_current_out,
    output logic                      doubler_out,
    output logic [RSYNC_W-1:0]        resync_out,
    // noise and spur settings
    output logic                      dither_enable_out,
    output logic                      cp_low_noise_out,
    // reference path and lock detect
    output logic                      comparison_pulse_out,
    output logic                      lock_detect_out
);
    // ==========================================================
    // state of the whole block in one record
    typedef struct packed {
        logic [N_REG_W-1:0]     n_divider_reg;
        logic [R_REG_W-1:0]     r_divider_reg;
        logic [CTRL_REG_W-1:0]  control_reg;
        logic [NOISE_REG_W-1:0] noise_spur_reg;
        logic [MOD_W-1:0]       mod_active;
        logic [MOD_W-1:0]       resync_delay;
        logic [SYNC_W-1:0]      s1;
        logic [SYNC_W-1:0]      s2;
        logic [SYNC_W-1:0]      s3;
        logic [SYNC_W-1:0]      lvl;
        logic [RDIV_W-1:0]      div_cnt;
        logic                   cmp_pulse;
        logic [LOCK_W-1:0]      lock_cnt;
        logic                   lock;
    } bank_state_t;

    bank_state_t st_r;
    bank_state_t st_nxt;

    // ==========================================================
    // received serial words
    logic [WORD_W-1:0] word;
    logic              word_valid;
    // word_valid is one cycle per latched word, already gated by the enable

    serial_word_receiver u_rx (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .ce_in          (ce_in),
        .ser_clk_in     (ser_clk_in),
        .ser_data_in    (ser_data_in),
        .ser_latch_in   (ser_latch_in),
        .word_out       (word),
        .word_valid_out (word_valid)
    );

    // ==========================================================
    // decode helpers; ref_ratio and is_sel are each used in more than one place
    // mode code: the four upper mode bits, then the single low one
    function automatic logic [NS_MODE_W-1:0] noise_mode(input logic [NOISE_REG_W-1:0] r);
        noise_mode = {r[NS_HI_LSB +: NS_MODE_W-1], r[NS_LO_BIT]};
    endfunction : noise_mode

    // a zero divider value is treated as divide by one
    function automatic logic [RDIV_W-1:0] ref_ratio(input logic [R_REG_W-1:0] r);
        logic [RDIV_W-1:0] v;
        v = r[R_RDIV_LSB +: RDIV_W];
        ref_ratio = (v == '0) ? RDIV_W'(1) : v;
    endfunction : ref_ratio

    // true when the two low control bits name the given register
    function automatic logic is_sel(input logic [WORD_W-1:0] w, input logic [1:0] sel);
        is_sel = (w[1:0] == sel);
    endfunction : is_sel

    // ==========================================================
    // combinational decode of current settings
    logic              ctl_crst;
    logic              ctl_pd;
    logic              ctl_dbl;
    logic              ctl_ldp;
    logic              hold_counters;
    logic              wr_n;
    logic              wr_r;
    logic              wr_ctrl;
    logic              wr_noise;
    logic              ref_rise;
    logic              ref_fall;
    logic              active_edge;
    logic              err_small;
    logic              err_large;
    logic [LOCK_W-1:0] lock_target;

    // power-down reaches the reference divider counter through the same hold term as counter reset
    assign ctl_crst      = st_r.control_reg[C_CRST_BIT];
    assign ctl_pd        = st_r.control_reg[C_PD_BIT];
    assign ctl_dbl       = st_r.control_reg[C_DBL_BIT];
    assign ctl_ldp       = st_r.control_reg[C_LDP_BIT];
    assign hold_counters = ctl_crst | ctl_pd;

    // word routing by the two low control bits
    assign wr_n     = word_valid & is_sel(word, SEL_N_DIV);
    assign wr_r     = word_valid & is_sel(word, SEL_R_DIV);
    assign wr_ctrl  = word_valid & is_sel(word, SEL_CTRL);
    assign wr_noise = word_valid & is_sel(word, SEL_NOISE);

    // a precision change applies from the next comparison cycle on
    // count target follows lock precision select
    assign lock_target = ctl_ldp ? LOCK_W'(LOCK_CYC_SLOW) : LOCK_W'(LOCK_CYC_FINE);

    // ==========================================================
    // next state
    always_comb begin
        st_nxt           = st_r;
        st_nxt.cmp_pulse = 1'b0;
        ref_rise         = 1'b0;
        ref_fall         = 1'b0;

        // three-stage synchronisers for reference and comparator pins
        st_nxt.s1 = {err_above_30ns_in, err_below_15ns_in, reference_input_in};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end
        // edges come only from agreed levels: a reference glitch shorter
        // than two clock cycles is ignored
        if (st_r.s2[0] == st_r.s3[0]) begin
            ref_rise = st_r.s3[0] & ~st_r.lvl[0];
            ref_fall = ~st_r.s3[0] & st_r.lvl[0];
        end
        err_small = st_r.lvl[1];
        err_large = st_r.lvl[2];

        // doubling is done by counting both reference edges
        // falling edge only unless the doubler is on
        active_edge = ctl_dbl ? (ref_rise | ref_fall) : ref_fall;

        // ------------------------------------------------------
        // register writes; each word touches its own target, and an n word also loads mod_active and clears lock detect
        // write-only bank, one register per word
        if (wr_n) begin
            st_nxt.n_divider_reg = word[N_REG_W-1:0];
            // a host that skips the n write keeps the old divisor running
            // second half of the double buffer
            st_nxt.mod_active = st_r.r_divider_reg[R_MOD_LSB +: MOD_W];
        end
        if (wr_r) begin
            if (word[R_LOAD_BIT]) begin
                // load bit set: value is the resync delay only
                st_nxt.resync_delay = word[R_MOD_LSB +: MOD_W];
            end else begin
                // divisor waits here until the next n write
                st_nxt.r_divider_reg = word[R_REG_W-1:0];
            end
        end
        // writes keep landing while powered down
        // input register stays active in power-down
        if (wr_ctrl) begin
            st_nxt.control_reg = word[CTRL_REG_W-1:0];
        end
        if (wr_noise) begin
            st_nxt.noise_spur_reg = word[NOISE_REG_W-1:0];
        end

        // ------------------------------------------------------
        // reference divider
        // limitation: the reference must hold each level two clock cycles,
        // so it has to run well below a quarter of the clock rate
        // counters held in reset while the reset bit is set
        if (hold_counters) begin
            st_nxt.div_cnt = '0;
        end else if (active_edge) begin
            // pulse once every ratio active edges
            if (st_r.div_cnt + RDIV_W'(1) >= ref_ratio(st_r.r_divider_reg)) begin
                st_nxt.div_cnt   = '0;
                st_nxt.cmp_pulse = 1'b1;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt + RDIV_W'(1);
            end
        end

        // ------------------------------------------------------
        // digital lock detect, judged once per comparison cycle
        // the next control value is used so lock falls with power-down itself
        if (st_nxt.control_reg[C_PD_BIT]) begin
            st_nxt.lock_cnt = '0;
            st_nxt.lock     = 1'b0;
        end else if (wr_n) begin
            st_nxt.lock_cnt = '0;
            st_nxt.lock     = 1'b0;
        end else if (st_r.cmp_pulse) begin
            if (err_large) begin
                // one large error cycle drops lock
                st_nxt.lock_cnt = '0;
                st_nxt.lock     = 1'b0;
            end else if (err_small) begin
                // saturation keeps the count from wrapping during a long lock
                // count consecutive good cycles, saturating
                if (st_r.lock_cnt < lock_target) begin
                    st_nxt.lock_cnt = st_r.lock_cnt + LOCK_W'(1);
                end
                if (st_r.lock_cnt + LOCK_W'(1) >= lock_target) begin
                    st_nxt.lock = 1'b1;
                end
            end else begin
                // between the two thresholds: streak broken, lock kept
                st_nxt.lock_cnt = '0;
            end
        end
    end

    // ==========================================================
    // registers; no hardware reset exists on the part, so zero is chosen
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r                <= '0;
            st_r.n_divider_reg  <= N_REG_RST;
            st_r.r_divider_reg  <= R_REG_RST;
            st_r.control_reg    <= CTRL_REG_RST;
            st_r.noise_spur_reg <= NOISE_REG_RST;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // divider outputs
    // integer, fraction and divisor feed the fractional divider
    assign whole_divide_value_out     = st_r.n_divider_reg[N_INT_LSB +: INT_W];
    assign partial_step_count_out     = st_r.n_divider_reg[N_FRAC_LSB +: FRAC_W];
    // only the buffered divisor reaches the interpolator
    assign channel_step_divisor_out   = st_r.mod_active;
    assign resync_delay_out           = st_r.resync_delay;
    // zero is shown as one, which is how the divider treats it
    assign ref_divider_out            = ref_ratio(st_r.r_divider_reg);
    assign fastlock_out               = st_r.n_divider_reg[N_FASTLOCK_BIT];
    assign prescaler_sel_out          = st_r.r_divider_reg[R_PRESC_BIT];
    assign multiplexed_output_sel_out = st_r.r_divider_reg[R_MUX_LSB +: MUX_W];

    // ==========================================================
    // control outputs
    // counter reset level to the analog counters
    assign counters_reset_out = hold_counters;
    // power-down forces three-state without touching the stored bit
    // three-state by bit or by power-down
    assign cp_three_state_out = st_r.control_reg[C_CP3_BIT] | ctl_pd;
    assign power_down_out     = ctl_pd;
    assign pd_polarity_out    = st_r.control_reg[C_POL_BIT];
    assign cp_current_out     = st_r.control_reg[C_CPI_LSB +: CPI_W];
    assign doubler_out        = ctl_dbl;
    assign resync_out         = st_r.control_reg[C_RSYNC_LSB +: RSYNC_W];

    // ==========================================================
    // noise and spur mode; unlisted codes fall back to dither on,
    // which is the safer choice for spurs
    always_comb begin
        case (noise_mode(st_r.noise_spur_reg))
            // low noise and spur: dither off
            MODE_LOW_NOISE_SPUR: begin
                dither_enable_out = 1'b0;
                cp_low_noise_out  = 1'b0;
            end
            // lowest noise: dither off, pump in low-noise region
            MODE_LOWEST_NOISE: begin
                dither_enable_out = 1'b0;
                cp_low_noise_out  = 1'b1;
            end
            default: begin
                dither_enable_out = 1'b1;
                cp_low_noise_out  = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // reference path and lock outputs
    assign comparison_pulse_out = st_r.cmp_pulse;
    assign lock_detect_out      = st_r.lock;
endmodule : synth_control_registers

// *** dv/synth_regs_monitor.sv ***
// port checks for the synthesizer register bank
`timescale 1ns/1ps
module synth_regs_monitor
    import synth_regs_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // watched outputs
    input  wire logic              counters_reset_out,
    input  wire logic              cp_three_state_out,
    input  wire logic              power_down_out,
    input  wire logic [RDIV_W-1:0] ref_divider_out,
    input  wire logic              dither_enable_out,
    input  wire logic              cp_low_noise_out,
    input  wire logic              comparison_pulse_out,
    input  wire logic              lock_detect_out
);
    // ==========================================================
    // assertions, all on the one system clock
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    pd_counters_a: assert property (power_down_out |-> counters_reset_out)
        else $error("power-down left counters running");
    pd_pump_a: assert property (power_down_out |-> cp_three_state_out)
        else $error("power-down left pump driving");
    pd_lock_a: assert property (power_down_out |-> !lock_detect_out)
        else $error("lock high during power-down");
    held_no_pulse_a: assert property (counters_reset_out [*6] |-> !comparison_pulse_out)
        else $error("comparison pulse while counters held");
    pulse_single_a: assert property (comparison_pulse_out |=> !comparison_pulse_out)
        else $error("comparison pulse longer than one cycle");
    ratio_nonzero_a: assert property (ref_divider_out != 4'h0)
        else $error("reference divide ratio zero");
    quiet_no_dither_a: assert property (cp_low_noise_out |-> !dither_enable_out)
        else $error("dither on in lowest noise mode");
    lock_rise_run_a: assert property ($rose(lock_detect_out) |-> !counters_reset_out)
        else $error("lock rose with counters held");
endmodule : synth_regs_monitor

// *** dv/serial_host_model.sv ***
// host side of the three-wire link: word msb first, then a latch pulse
`timescale 1ns/1ps
module serial_host_model (
    // clock
    input  wire logic clk_in,
    // serial pins
    output logic      ser_clk_out = 1'b0,
    output logic      ser_data_out = 1'b0,
    output logic      ser_latch_out = 1'b0
);
    // four cycles a level, two more than the receiver needs to agree
    task automatic hold();
        repeat (4) @(posedge clk_in);
    endtask : hold
    // callers pass reserved bits as zero, apart from bits 16 to 23 of the random control words
    task automatic send(input logic [23:0] w);
        @(posedge clk_in);
        for (int i = 23; i >= 0; i--) begin
            ser_data_out <= w[i];
            hold();
            ser_clk_out <= 1'b1;
            hold();
            ser_clk_out <= 1'b0;
            hold();
        end
        ser_data_out <= ~w[0];  // no stale bit left on the released line
        ser_latch_out <= 1'b1;
        hold();
        ser_latch_out <= 1'b0;
        hold();
    endtask : send
endmodule : serial_host_model

// *** dv/synth_control_registers_tb_top.sv ***
// bench: host model loads words, a register model predicts every output except comparison_pulse_out and lock_detect_out
`timescale 1ns/1ps
module synth_control_registers_tb_top;
    import synth_regs_pkg::*;
    logic clk_in = 0, rst_in = 1, ce_in = 1, reference_input_in = 0;
    logic err_below_15ns_in = 0, err_above_30ns_in = 0, ser_clk_in, ser_data_in, ser_latch_in;
    logic [INT_W-1:0]   whole_divide_value_out;
    logic [FRAC_W-1:0]  partial_step_count_out;
    logic [MOD_W-1:0]   channel_step_divisor_out, resync_delay_out;
    logic [RDIV_W-1:0]  ref_divider_out;
    logic [MUX_W-1:0]   multiplexed_output_sel_out;
    logic [CPI_W-1:0]   cp_current_out;
    logic [RSYNC_W-1:0] resync_out;
    logic fastlock_out, prescaler_sel_out, counters_reset_out, cp_three_state_out;
    logic power_down_out, pd_polarity_out, doubler_out, dither_enable_out, cp_low_noise_out;
    logic comparison_pulse_out, lock_detect_out;
    logic [23:0] n_m = 0, r_m = 0, c_m = 0, pend = 0, mod_m = 0, rsd_m = 0, w;
    logic [4:0]  ns = 0;
    logic [31:0] seed = 1259;
    int num_errors = 0, n_compared = 0, p;
    // ==========================================================
    // clock, free-running reference and instances
    initial forever #50 clk_in = ~clk_in;
    always begin
        repeat (8) @(posedge clk_in);
        reference_input_in <= ~reference_input_in;
    end
    serial_host_model host (.clk_in(clk_in), .ser_clk_out(ser_clk_in),
                            .ser_data_out(ser_data_in), .ser_latch_out(ser_latch_in));
    synth_control_registers DUT (.*);
    // ==========================================================
    // helpers
    function automatic logic [23:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[23:0];
    endfunction : rnd
    task automatic end_sim();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic check_regs();
        chk(whole_divide_value_out, n_m[22:14]);
        chk(partial_step_count_out, n_m[13:2]);
        chk(channel_step_divisor_out, mod_m);
        chk(resync_delay_out, rsd_m);
        chk(ref_divider_out, (r_m[17:14] == 4'h0) ? 4'h1 : r_m[17:14]);
        chk({counters_reset_out, cp_three_state_out}, {c_m[2] | c_m[4], c_m[3] | c_m[4]});
        chk({power_down_out, pd_polarity_out, cp_current_out, doubler_out},
            {c_m[4], c_m[6], c_m[10:7], c_m[11]});
        chk({fastlock_out, prescaler_sel_out, multiplexed_output_sel_out, resync_out},
            {n_m[23], r_m[18], r_m[22:20], c_m[15:12]});
        chk({dither_enable_out, cp_low_noise_out},
            {!(ns == 5'h1C || ns == 5'h1F), ns == 5'h1F});
    endtask : check_regs
    // write one word, let it land, update the model and compare
    task automatic wr(input logic [23:0] v);
        host.send(v);
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
        case (v[1:0])
            2'b00: begin
                n_m = v;
                mod_m = pend;
            end
            2'b01: begin
                if (v[23]) rsd_m = v[13:2];
                else begin
                    r_m = v;
                    pend = v[13:2];
                end
            end
            2'b10: c_m = v;
            default: ns = {v[9:6], v[2]};
        endcase
        check_regs();
    endtask : wr
    task automatic wait_pulse();
        for (int k = 0; k < 5000; k++) begin
            @(negedge clk_in);
            if (comparison_pulse_out === 1'b1) return;
        end
        num_errors++;
        end_sim();
    endtask : wait_pulse
    // large error drops lock, then good cycles are counted until lock
    task automatic lock_run(input logic lock_precision_select, input int need);
        wr(24'h00_03C2 | {12'h000, lock_precision_select, 5'h00, lock_precision_select, 5'h00});
        @(posedge clk_in);
        err_above_30ns_in <= 1'b1;
        err_below_15ns_in <= 1'b0;
        wait_pulse();
        wait_pulse();
        @(negedge clk_in);
        chk(lock_detect_out, 1'b0);
        @(posedge clk_in);
        err_above_30ns_in <= 1'b0;
        err_below_15ns_in <= 1'b1;
        p = 0;
        for (int k = 0; k < 60 && lock_detect_out !== 1'b1; k++) begin
            wait_pulse();
            repeat (3) @(negedge clk_in);
            p++;
        end
        chk(p, need);
    endtask : lock_run
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        check_regs();
        wr(24'h00_0003);
        wr(24'h00_03C7);
        wr(24'h00_0383);
        wr(24'h00_0006);
        wr(24'h80_0329);
        wr(24'h00_4105);
        wr(24'h22_8078);
        wr(24'h00_0002);
        for (int i = 0; i < 12; i++) begin
            w = rnd();
            if (i % 4 == 3) w &= 24'h00_03C4;
            if (i % 4 == 1) w &= 24'hF7_FFFF;
            if (i % 4 == 0) w &= 24'hFF_C007;
            wr({w[23:2], 2'(i % 4)});
        end
        wr(24'h00_4105);
        wr(24'h22_8078);
        lock_run(1'b0, 24);
        lock_run(1'b1, 40);
        // clock enable low: a word sent meanwhile is never seen
        wait_pulse();
        @(posedge clk_in);
        ce_in <= 1'b0;
        host.send(24'h00_0016);
        ce_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
        check_regs();
        wr(24'h00_0012);
        chk(lock_detect_out, 1'b0);
        end_sim();
    end
endmodule : synth_control_registers_tb_top
bind synth_control_registers synth_regs_monitor mon (
    .clk_in(clk_in), .rst_in(rst_in), .counters_reset_out(counters_reset_out),
    .cp_three_state_out(cp_three_state_out), .power_down_out(power_down_out),
    .ref_divider_out(ref_divider_out), .dither_enable_out(dither_enable_out),
    .cp_low_noise_out(cp_low_noise_out), .comparison_pulse_out(comparison_pulse_out),
    .lock_detect_out(lock_detect_out));
